// [verilog/program_sequencer_stack.sv]
// Purpose: Four-phase program sequencer with return-address stack
// Assumes: Program memory answers imem_data by phase four of the fetch
// Notes: Registers on APB; stack and its pointer are hidden from software
//
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
module program_sequencer_stack (
  input wire logic pclk, // System clock, 25 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable, freezes all state
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic [seq_pkg::PC_W-1:0] imem_addr, // Fetch address
  output logic imem_rd, // Fetch strobe
  input wire logic [13:0] imem_data, // Fetched word
  input wire logic int_req, // Interrupt request pulse
  output logic int_ack, // Interrupt acknowledge pulse
  output seq_pkg::phase_t instruction_clock_phases // Phase register, registered one pclk late
);
  import seq_pkg::*;

  phase_t phase_reg;
  logic [3:0] div_reg;
  logic tick;
  logic [2:0] ctrl_reg;
  logic [PC_W-1:0] pc_reg;
  instr_t fetch_reg;
  instr_t exec_reg;
  logic exec_valid_reg;
  logic flush_reg;
  logic pc_low_pend_reg;
  logic [7:0] pc_low_data_reg;
  logic int_flag_reg;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [SP_W-1:0] top_reg;
  logic [LVL_W-1:0] level_reg;
  logic stack_full;
  logic t4;
  logic do_jmp, do_call, do_return, do_skip, do_pc_low, do_int;
  logic redirect;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] pop_addr;
  logic alu_skip;
  logic [7:0] acc;
  logic apb_acc;
  logic mapped;

  function automatic logic is_cls(input instr_t i, input logic [2:0] c);
    is_cls = (i.cls == c);
  endfunction

  // Slow source emulated by dividing pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_reg <= 4'h0;
    else if (ce)
      div_reg <= (div_reg == SLOW_DIV_LAST) ? 4'h0 : div_reg + 4'h1;
  end

  assign tick = ce && ctrl_reg[CTRL_RUN_BIT] &&
                (!ctrl_reg[CTRL_SLOW_BIT] || div_reg == SLOW_DIV_LAST);
  assign t4 = tick && (phase_reg == PH_T4);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      phase_reg <= PH_T1;
    else if (tick)
    begin
      case (phase_reg)
        PH_T1: phase_reg <= PH_T2;
        PH_T2: phase_reg <= PH_T3;
        PH_T3: phase_reg <= PH_T4;
        PH_T4: phase_reg <= PH_T1;
        default: phase_reg <= PH_T1;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      instruction_clock_phases <= PH_T1;
    else if (ce)
      instruction_clock_phases <= phase_reg;
  end

  // Execute-phase decisions; instruction effects outrank software and interrupts
  assign stack_full = (level_reg == STACK_FULL_LVL);
  assign do_jmp = t4 && exec_valid_reg && is_cls(exec_reg, CLS_JMP);
  assign do_call = t4 && exec_valid_reg && is_cls(exec_reg, CLS_CALL);
  assign do_return = t4 && exec_valid_reg && is_cls(exec_reg, CLS_RETURN);
  assign do_skip = t4 && exec_valid_reg && is_cls(exec_reg, CLS_ALU) && alu_skip;
  // Skip keeps the counter, so a low byte write or interrupt waits a phase four
  assign do_pc_low = t4 && pc_low_pend_reg && !(do_jmp || do_call || do_return || do_skip);
  assign do_int = t4 && int_flag_reg && ctrl_reg[CTRL_INTEN_BIT] && !stack_full &&
                  !(do_jmp || do_call || do_return || do_skip || do_pc_low);
  assign redirect = do_jmp || do_call || do_return || do_skip || do_pc_low || do_int;
  assign pop_addr = stack_mem[top_reg - 3'h1];

  always_comb
  begin
    target = pc_reg;
    if (do_jmp || do_call)
      target = {exec_reg.op, exec_reg.lit};
    else if (do_return)
      target = pop_addr;
    else if (do_pc_low)
      target = {pc_reg[PC_W-1:8], pc_low_data_reg};
    else if (do_int)
      target = INT_VECTOR;
  end

  // Counter advances at phase one, reloads at phase four on a redirect other than a skip
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pc_reg <= RESET_VECTOR;
    else if (tick && phase_reg == PH_T1)
      pc_reg <= pc_reg + 11'h001;
    else if (redirect && !do_skip)
      pc_reg <= target;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      imem_addr <= RESET_VECTOR;
      imem_rd <= 1'b0;
    end
    else if (ce)
    begin
      imem_rd <= tick && (phase_reg == PH_T1);
      if (tick && phase_reg == PH_T1)
        imem_addr <= pc_reg;
    end
  end

  // Prefetch captured while the previous word executes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fetch_reg <= '0;
    else if (t4)
      fetch_reg <= instr_t'(imem_data);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      exec_reg <= '0;
      exec_valid_reg <= 1'b0;
    end
    else if (tick && phase_reg == PH_T1)
    begin
      exec_reg <= fetch_reg;
      exec_valid_reg <= !flush_reg;
    end
  end

  // Starts set so the empty prefetch after reset is never executed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flush_reg <= 1'b1;
    else if (redirect)
      flush_reg <= 1'b1;
    else if (tick && phase_reg == PH_T1)
      flush_reg <= 1'b0;
  end

  alu_acc u_alu (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .apply(t4 && exec_valid_reg && is_cls(exec_reg, CLS_ALU)),
    .op(exec_reg.op),
    .lit(exec_reg.lit),
    .acc(acc),
    .skip(alu_skip)
  );

  // Request stays latched while the stack is full
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_flag_reg <= 1'b0;
    else if (ce && int_req)
      int_flag_reg <= 1'b1;
    else if (do_int)
      int_flag_reg <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      int_ack <= 1'b0;
    else if (ce)
      int_ack <= do_int;
  end

  // Circular stack: a push when full overwrites the oldest slot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      top_reg <= '0;
      level_reg <= '0;
    end
    else if (do_call || do_int)
    begin
      top_reg <= top_reg + 3'h1;
      if (!stack_full)
        level_reg <= level_reg + 4'h1;
    end
    else if (do_return)
    begin
      top_reg <= top_reg - 3'h1;
      if (level_reg != 4'h0)
        level_reg <= level_reg - 4'h1;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (do_call || do_int)
      stack_mem[top_reg] <= imem_addr;
  end

  // APB slave: one wait state, every access answered
  assign apb_acc = psel && penable && !pready;
  assign mapped = (paddr == CTRL_OFF) || (paddr == PC_LOW_OFF) ||
                  (paddr == STATUS_OFF) || (paddr == ACC_OFF);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (ce)
    begin
      pready <= apb_acc;
      pslverr <= apb_acc && !mapped;
      prdata <= 32'h0000_0000;
      if (apb_acc && !pwrite)
      begin
        case (paddr)
          CTRL_OFF: prdata <= {29'h0, ctrl_reg};
          PC_LOW_OFF: prdata <= {24'h0, pc_reg[7:0]};
          STATUS_OFF:
          begin
            prdata[ST_PC_LSB +: PC_W] <= pc_reg;
            prdata[ST_FULL_BIT] <= stack_full;
            prdata[ST_PHASE_LSB +: 4] <= phase_reg;
            prdata[ST_INTPEND_BIT] <= int_flag_reg;
          end
          ACC_OFF: prdata <= {24'h0, acc};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_reg <= CTRL_RESET;
    else if (ce && apb_acc && pwrite && paddr == CTRL_OFF)
      ctrl_reg <= pwdata[2:0];
  end

  // A new write in the consuming cycle stays pending
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_low_pend_reg <= 1'b0;
      pc_low_data_reg <= 8'h00;
    end
    else if (ce && apb_acc && pwrite && paddr == PC_LOW_OFF)
    begin
      pc_low_pend_reg <= 1'b1;
      pc_low_data_reg <= pwdata[7:0];
    end
    else if (do_pc_low)
      pc_low_pend_reg <= 1'b0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  phase_order_a: assert property (t4 |=> phase_reg == PH_T1)
    else $error("phase four not followed by phase one");
  phase_onehot_a: assert property ($onehot(phase_reg))
    else $error("phase not one-hot");
  fetch_phase_a: assert property (tick && phase_reg == PH_T1 |=> imem_rd && imem_addr == $past(pc_reg))
    else $error("fetch not issued at phase one");
  pc_increment_a: assert property (tick && phase_reg == PH_T1 |=> pc_reg == $past(pc_reg) + 11'h001)
    else $error("counter did not increment");
  jump_load_a: assert property (do_jmp |=> pc_reg == {$past(exec_reg.op), $past(exec_reg.lit)})
    else $error("jump target not loaded");
  branch_flush_a: assert property (tick && phase_reg == PH_T1 && flush_reg |=> !exec_valid_reg)
    else $error("prefetch not discarded");
  pc_low_page_a: assert property (do_pc_low |=> pc_reg[PC_W-1:8] == $past(pc_reg[PC_W-1:8]))
    else $error("page bits changed on low byte write");
  push_level_a: assert property ((do_call || do_int) && !stack_full |=> level_reg == $past(level_reg) + 4'h1)
    else $error("push did not raise level");
  full_call_a: assert property (do_call && stack_full |=> stack_full && pc_reg == $past(target))
    else $error("call on full stack mishandled");
  full_ack_a: assert property (int_ack |-> !$past(stack_full) && $past(int_flag_reg))
    else $error("acknowledge with full stack");
  return_restore_a: assert property (do_return |=> pc_reg == $past(pop_addr))
    else $error("return did not restore counter");

  call_c: cover property (do_call);
  return_c: cover property (do_return);
  skip_c: cover property (do_skip);
  int_full_c: cover property (int_flag_reg && stack_full ##1 do_return ##[1:40] int_ack);
endmodule

// [common/seq_pkg.sv]
// Purpose: Shared constants and types for the program sequencer
// Assumes: 14-bit instruction words, 11-bit program counter
// Notes: Register offsets are byte addresses on a 32-bit APB
package seq_pkg;
  localparam int PC_W = 11;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int LVL_W = 4;
  localparam logic [LVL_W-1:0] STACK_FULL_LVL = 4'h8;
  localparam logic [PC_W-1:0] RESET_VECTOR = 11'h000;
  localparam logic [PC_W-1:0] INT_VECTOR = 11'h004;
  // Slow oscillator emulated as one phase per sixteen pclk
  localparam logic [3:0] SLOW_DIV_LAST = 4'hf;

  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] PC_LOW_OFF = 8'h04;
  localparam logic [7:0] STATUS_OFF = 8'h08;
  localparam logic [7:0] ACC_OFF = 8'h0c;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SLOW_BIT = 1;
  localparam int CTRL_INTEN_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;

  localparam int ST_PC_LSB = 0;
  localparam int ST_FULL_BIT = 11;
  localparam int ST_PHASE_LSB = 12;
  localparam int ST_INTPEND_BIT = 16;

  localparam logic [2:0] CLS_ALU = 3'h0;
  localparam logic [2:0] CLS_RETURN = 3'h2;
  localparam logic [2:0] CLS_JMP = 3'h6;
  localparam logic [2:0] CLS_CALL = 3'h7;

  localparam logic [2:0] OP_NOP = 3'h0;
  localparam logic [2:0] OP_MOV = 3'h1;
  localparam logic [2:0] OP_ADD = 3'h2;
  localparam logic [2:0] OP_AND = 3'h3;
  localparam logic [2:0] OP_OR = 3'h4;
  localparam logic [2:0] OP_XOR = 3'h5;
  localparam logic [2:0] OP_SZ = 3'h6;
  localparam logic [2:0] OP_DSZ = 3'h7;

  typedef enum logic [3:0] {
    PH_T1 = 4'b0001,
    PH_T2 = 4'b0010,
    PH_T3 = 4'b0100,
    PH_T4 = 4'b1000
  } phase_t;

  // Jump and call targets are {op, lit}
  typedef struct packed {
    logic [2:0] cls;
    logic [2:0] op;
    logic [7:0] lit;
  } instr_t;
endpackage

// [verilog/alu_acc.sv]
// Purpose: Eight-bit ALU with accumulator and skip decision
// Assumes: apply is a one-cycle strobe at the execute phase
// Notes: skip is combinational from the current accumulator
`timescale 1ns/1ps
module alu_acc (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic ce, // Clock enable
  input wire logic apply, // Execute strobe
  input wire logic [2:0] op, // Operation code
  input wire logic [7:0] lit, // Literal operand
  output logic [7:0] acc, // Accumulator
  output logic skip // Skip condition met
);
  import seq_pkg::*;

  logic [7:0] acc_next;

  always_comb
  begin
    acc_next = acc;
    skip = 1'b0;
    case (op)
      OP_MOV: acc_next = lit;
      OP_ADD: acc_next = acc + lit;
      OP_AND: acc_next = acc & lit;
      OP_OR: acc_next = acc | lit;
      OP_XOR: acc_next = acc ^ lit;
      OP_SZ: skip = (acc == 8'h00);
      OP_DSZ:
      begin
        acc_next = acc - 8'h01;
        skip = (acc == 8'h01);
      end
      default: acc_next = acc;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc <= 8'h00;
    else if (ce && apply)
      acc <= acc_next;
  end
endmodule

// [tb/prog_mem_model.sv]
// Purpose: Program memory and interrupt source beside the sequencer
// Assumes: imem_addr holds until the next fetch strobe
// Notes: Slow answers show junk while the strobe is high
`timescale 1ns/1ps
module prog_mem_model (
  input wire logic pclk, // System clock
  input wire logic presetn, // Reset, active low
  input wire logic [10:0] imem_addr, // Fetch address
  input wire logic imem_rd, // Fetch strobe
  output logic [13:0] imem_data, // Fetched word
  input wire logic slow_ans, // Answer one cycle late
  input wire logic int_fire, // Raise a request
  output logic int_req, // Interrupt request
  input wire logic int_ack // Interrupt acknowledge
);
  logic [13:0] mem [0:2047];
  logic [13:0] last;
  logic [7:0] ack_cnt;
  initial
  begin
    for (int i = 0; i < 2048; i++)
      mem[i] = 14'h0199;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      last <= 14'h0;
      int_req <= 1'b0;
      ack_cnt <= 8'h00;
    end
    else
    begin
      last <= imem_data;
      // One-cycle pulse: the flag latches it, a held level would be taken twice
      int_req <= int_fire;
      if (int_ack)
        ack_cnt <= ack_cnt + 8'h01;
    end
  end
  // Inverted word so a too-early sample never matches by luck
  assign imem_data = (slow_ans && imem_rd) ? ~last : mem[imem_addr];
endmodule

// [tb/testbench.sv]
// Purpose: Self-checking bench for the program sequencer
// Assumes: Fast phase tick every pclk, slow every sixteen
// Notes: Program words are planted in the memory model
`timescale 1ns/1ps
module testbench;
  import seq_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic imem_rd, int_req, int_ack, slow_ans, int_fire, watch;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [PC_W-1:0] imem_addr;
  logic [13:0] imem_data;
  phase_t phs;
  int miscompares, n_compared;
  logic [PC_W-1:0] fq[$];
  logic [33:0] aq[$];
  logic [31:0] mq[$];
  localparam logic [10:0] SEQ [14] = '{11'h000, 11'h001, 11'h008, 11'h009, 11'h00a, 11'h00b, 11'h00c,
    11'h010, 11'h011, 11'h012, 11'h00c, 11'h00d, 11'h00e, 11'h120};

  program_sequencer_stack dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .imem_addr(imem_addr), .imem_rd(imem_rd), .imem_data(imem_data), .int_req(int_req), .int_ack(int_ack),
    .instruction_clock_phases(phs));
  prog_mem_model pm (.pclk(pclk), .presetn(presetn), .imem_addr(imem_addr), .imem_rd(imem_rd),
    .imem_data(imem_data), .slow_ans(slow_ans), .int_fire(int_fire), .int_req(int_req), .int_ack(int_ack));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d compared, %0d mismatched", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Kind 0 queues empty, 1 fetch of a, 2 acknowledge, 3 any fetch
  task automatic wait_until(input int kind, input logic [10:0] a, input int n);
    bit hit;
    hit = 0;
    repeat (n)
    begin
      @(posedge pclk);
      #1;
      hit = kind == 0 ? (fq.size() == 0 && aq.size() == 0) : kind == 1 ? (imem_rd === 1'b1 && imem_addr === a)
        : kind == 2 ? int_ack === 1'b1 : imem_rd === 1'b1;
      if (hit)
        break;
    end
    if (!hit)
    begin
      miscompares++;
      $display("[ERR] wait %0d expected hit seen timeout", kind);
      close_out();
    end
  endtask

  // Expectation is {read, error, data}; mask picks data bits
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e,
    input logic [31:0] m);
    bit got;
    @(posedge pclk);
    aq.push_back(e);
    mq.push_back(m);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    got = 1'b0;
    for (int i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      got = (pready === 1'b1);
      if (got)
        break;
    end
    if (got)
    begin
      psel <= 1'b0;
      penable <= 1'b0;
    end
    else
    begin
      miscompares++;
      $display("[ERR] pready expected 1 seen timeout");
      close_out();
    end
  endtask

  task automatic gap(input int exp);
    int n;
    logic [3:0] seen;
    n = 0;
    seen = 4'h0;
    wait_until(3, 11'h0, 200);
    do
    begin
      @(posedge pclk);
      #1;
      n++;
      seen |= phs;
    end
    while (imem_rd !== 1'b1 && n < 200);
    check("fetch spacing", n, exp);
    check("phases seen", seen, 4'hf);
  endtask

  task automatic run_seq();
    foreach (SEQ[i])
      fq.push_back(SEQ[i]);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    // Armed only once reset has cleared any fetch still in flight
    watch = 1'b1;
    presetn <= 1'b1;
    wait_until(0, 11'h0, 300);
    watch = 1'b0;
    apb(0, CTRL_OFF, 0, {2'b10, 32'h1}, '1);
    apb(0, STATUS_OFF, 0, {2'b10, 32'h0}, 32'h800);
    apb(0, ACC_OFF, 0, {2'b10, 32'h34}, '1);
    $display("Test fetch sequence done");
  endtask

  always @(posedge pclk)
    if (imem_rd === 1'b1 && watch && fq.size() > 0)
      check("fetch address", imem_addr, fq.pop_front());

  always @(posedge pclk)
    if (pready === 1'b1 && aq.size() > 0)
    begin
      check("pslverr", pslverr, aq[0][32]);
      if (aq[0][33])
        check("prdata", prdata & mq[0], aq[0][31:0] & mq[0]);
      void'(aq.pop_front());
      void'(mq.pop_front());
    end

  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, slow_ans, int_fire, watch} = '0;
    ce = 1'b1;
    presetn = 1'b0;
    miscompares = 0;
    n_compared = 0;
    r = $urandom(91125);
    pm.mem[0] = {CLS_JMP, 11'h008};
    pm.mem[4] = {CLS_RETURN, 11'h001};
    pm.mem[8] = {CLS_ALU, OP_MOV, 8'h00};
    pm.mem[9] = {CLS_ALU, OP_SZ, 8'h00};
    pm.mem[10] = {CLS_ALU, OP_MOV, 8'h55};
    pm.mem[11] = {CLS_CALL, 11'h010};
    pm.mem[12] = {CLS_ALU, OP_ADD, 8'h33};
    pm.mem[13] = {CLS_JMP, 11'h120};
    pm.mem[16] = {CLS_ALU, OP_ADD, 8'h01};
    pm.mem[17] = {CLS_RETURN, 11'h000};
    pm.mem['h120] = {CLS_JMP, 11'h120};
    pm.mem['h140] = {CLS_JMP, 11'h140};
    pm.mem['h141] = {CLS_JMP, 11'h140};
    for (int k = 0; k < 9; k++)
      pm.mem['h300 + k] = {CLS_CALL, 11'h301 + 11'(k)};
    pm.mem['h309] = {CLS_JMP, 11'h309};
    pm.mem['h30a] = {CLS_JMP, 11'h309};
    run_seq();
    r = $urandom();
    apb(1, STATUS_OFF, r, {2'b00, 32'h0}, '0);
    apb(1, 8'hfc, r, {2'b01, 32'h0}, '0);
    apb(0, 8'h10, 0, {2'b11, 32'h0}, '1);
    apb(0, ACC_OFF, 0, {2'b10, 32'h34}, '1);
    apb(1, PC_LOW_OFF, 32'h40, {2'b00, 32'h0}, '0);
    wait_until(1, 11'h140, 100);
    $display("Test page jump done");
    gap(4);
    // Clock enable low must freeze phase and fetch address
    ce <= 1'b0;
    @(posedge pclk);
    r = {17'h0, phs, imem_addr};
    repeat (16)
    begin
      @(posedge pclk);
      check("frozen state", {17'h0, phs, imem_addr}, r);
    end
    ce <= 1'b1;
    apb(1, CTRL_OFF, 32'h3, {2'b00, 32'h0}, '0);
    wait_until(3, 11'h0, 200);
    gap(64);
    apb(1, CTRL_OFF, 32'h5, {2'b00, 32'h0}, '0);
    gap(4);
    $display("Test phase timing done");
    int_fire <= 1'b1;
    @(posedge pclk);
    int_fire <= 1'b0;
    wait_until(2, 11'h0, 100);
    wait_until(1, INT_VECTOR, 20);
    $display("Test interrupt done");
    pm.mem['h140] = {CLS_JMP, 11'h300};
    pm.mem['h141] = {CLS_JMP, 11'h300};
    wait_until(1, 11'h309, 300);
    int_fire <= 1'b1;
    @(posedge pclk);
    int_fire <= 1'b0;
    repeat (60)
    begin
      @(posedge pclk);
      check("held ack", int_ack, 1'b0);
    end
    apb(0, STATUS_OFF, 0, {2'b10, 32'h10800}, 32'h10800);
    pm.mem['h309] = {CLS_RETURN, 11'h000};
    wait_until(2, 11'h0, 100);
    // One acknowledge per request: a second one would show here
    repeat (8) @(posedge pclk);
    check("acknowledge count", pm.ack_cnt, 32'h2);
    $display("Test full stack done");
    slow_ans <= 1'b1;
    run_seq();
    wait_until(0, 11'h0, 100);
    close_out();
  end
endmodule
